/* scdb_pkg.sv */
// Shared constants, types and helper functions of the serial channel data buffers.
// Assumes a 32-bit AHB-Lite register port; addresses are byte addresses in a 4 KB window.
package scdb_pkg;

    localparam int DATA_W    = 16;
    localparam int ADDR_W    = 12;
    localparam int WLEN_W    = 4;
    localparam int TCI_W     = 5;
    localparam int TCI_LSB   = 2;
    localparam int HSIZE_W   = 3;

    typedef logic [DATA_W-1:0] scdb_word_t;
    typedef logic [ADDR_W-1:0] scdb_addr_t;

    // Register byte offsets
    localparam scdb_addr_t TX_ENTRY_FIRST   = 12'h000;
    localparam scdb_addr_t TX_ENTRY_LAST    = 12'h07c;
    localparam scdb_addr_t RX_BUFFER_A      = 12'h080;
    localparam scdb_addr_t RX_BUFFER_B      = 12'h084;
    localparam scdb_addr_t RX_STATUS_LOW    = 12'h088;
    localparam scdb_addr_t RX_STATUS_HIGH   = 12'h08c;
    localparam scdb_addr_t COMBINED_RX_VIEW = 12'h090;
    localparam scdb_addr_t FLAG_MODIFY      = 12'h094;
    localparam scdb_addr_t TX_CTRL_STATUS   = 12'h098;
    localparam scdb_addr_t PROTO_STATUS     = 12'h09c;

    // Receive status layout
    localparam int ST_WLEN_LSB   = 0;
    localparam int ST_SOF_BIT    = 6;
    localparam int ST_PAR_BIT    = 8;
    localparam int ST_PERR_BIT   = 9;
    localparam int ST_VALID_A    = 13;
    localparam int ST_VALID_B    = 14;
    localparam int ST_SELECT_BIT = 15;

    // Flag modification layout and codes
    localparam int FM_MODIFY_LSB = 0;
    localparam int FM_CLEAR_A    = 14;
    localparam int FM_CLEAR_B    = 15;
    localparam logic [1:0] MODIFY_SET   = 2'h1;
    localparam logic [1:0] MODIFY_CLEAR = 2'h2;

    // Transmit control status and protocol status layout
    localparam int TCS_VALID_BIT   = 0;
    localparam int TCS_TRIGGER_BIT = 1;
    localparam int TCS_TCI_LSB     = 8;
    localparam int PS_DONE_BIT     = 0;
    localparam int PS_ALT_BIT      = 1;

    localparam logic [HSIZE_W-1:0] HSIZE_BYTE = 3'h0;
    localparam logic [HSIZE_W-1:0] HSIZE_HALF = 3'h1;
    localparam logic [31:0]        WORD_ZERO  = 32'h0000_0000;
    localparam scdb_word_t         ONES_WORD  = 16'hffff;

    // Byte lanes touched by an AHB transfer
    function automatic logic [3:0] lane_mask(input logic [HSIZE_W-1:0] size,
                                             input logic [1:0] lo);
        logic [3:0] m;
        m = 4'hf;
        if (size == HSIZE_BYTE) begin
            m = 4'h1 << lo;
        end else if (size == HSIZE_HALF) begin
            m = lo[1] ? 4'hc : 4'h3;
        end
        return m;
    endfunction : lane_mask

    // Keeps the received bits, right-aligned; bits is count minus one
    function automatic scdb_word_t word_mask(input logic [WLEN_W-1:0] bits);
        return ONES_WORD >> (4'hf - bits);
    endfunction : word_mask

endpackage : scdb_pkg

/* scdb_slot_if.sv */
// Contents and status of one receive buffer, passed between the buffer and the register bank.
// Assumes both ends run on the same module clock.
`timescale 1ns/1ps
interface scdb_slot_if;
    import scdb_pkg::*;
    scdb_word_t              word;
    logic [WLEN_W-1:0]       bits;
    logic                    sof;
    logic                    par;
    logic                    perr;
    logic                    valid;
    logic                    clear;
    modport slot (output word, bits, sof, par, perr, valid, input clear);
    modport ctrl (input word, bits, sof, par, perr, valid, output clear);
endinterface : scdb_slot_if

/* scdb_rx_slot.sv */
// One receive buffer with its word length, frame start, argument, error and valid bit.
// Assumes load is a one-cycle pulse from the protocol engine's receive shift register.
`timescale 1ns/1ps
module scdb_rx_slot
    import scdb_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire logic                  load,
    input  wire scdb_pkg::scdb_word_t  loadData,
    input  wire logic [WLEN_W-1:0]     loadBits,
    input  wire logic                  loadSof,
    input  wire logic                  loadPar,
    input  wire logic                  loadExpect,
    scdb_slot_if.slot                  sl
);
    import scdb_pkg::*;

    scdb_word_t        word_q;
    logic [WLEN_W-1:0] bits_q;
    logic              sof_q;
    logic              par_q;
    logic              perr_q;
    logic              valid_q;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            word_q <= '0;
            bits_q <= '0;
            sof_q  <= 1'b0;
            par_q  <= 1'b0;
            perr_q <= 1'b0;
        end else if (load) begin
            word_q <= loadData & word_mask(loadBits); // R8
            bits_q <= loadBits; // R8
            sof_q  <= loadSof; // R9
            par_q  <= loadPar; // R10
            perr_q <= loadPar != loadExpect; // R11 R12
        end
    end

    // A new word wins over a clear in the same cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            valid_q <= 1'b0;
        end else if (load) begin
            valid_q <= 1'b1; // R13 R14
        end else if (sl.clear) begin
            valid_q <= 1'b0; // R13 R14
        end
    end

    assign sl.word  = word_q;
    assign sl.bits  = bits_q;
    assign sl.sof   = sof_q;
    assign sl.par   = par_q;
    assign sl.perr  = perr_q;
    assign sl.valid = valid_q;

    a_upper_bits_zero: assert property (@(posedge clk) disable iff (reset) // R8
        load |=> (word_q & ~word_mask(bits_q)) == '0 && bits_q == $past(loadBits))
        else $error("unused upper receive bits not cleared");
    a_frame_start_copy: assert property (@(posedge clk) disable iff (reset) // R9
        load |=> sof_q == $past(loadSof) && par_q == $past(loadPar))
        else $error("frame start or argument not captured");
    a_error_on_mismatch: assert property (@(posedge clk) disable iff (reset) // R12
        load |=> perr_q == ($past(loadPar) != $past(loadExpect)))
        else $error("protocol error bit wrong");

endmodule : scdb_rx_slot

/* scdb_buffers.sv */
// Data buffer register bank of one serial channel: transmit buffer and two receive buffers.
// Assumes an AHB-Lite master on the register port and a protocol engine on the shift side.
//
// How it works
// (R1) Thirty-two write addresses share one transmit buffer
// (R2) Written address index becomes five-bit control info
// (R3) Any transmit address reads the transmit buffer
// (R4) Transmit buffer feeds the shift register
// (R5) Low-byte write sets transmit word valid
// (R6) Buffer A fills from shift register A
// (R7) Buffer B fills from shift register B
// (R8) Word length is bits minus one, upper cleared
// (R9) Status bit 6 marks frame start word
// (R10) Status bit 8 holds protocol argument
// (R11) Argument match sets normal receive flag
// (R12) Mismatch sets bit 9 and alternate flag
// (R13) Valid A set on store, cleared by view
// (R14) Valid B set on store, cleared by view
// (R15) High status keeps identical valid and selector copies
// (R16) Status bit 15 selects oldest buffer
// (R17) Reserved status bits read as zero
// (R18) Clear-valid-A write clears both its copies
// (R19) Modify code 10 clears valid, trigger; 01 sets
// (R20) Selector moves on after oldest word consumed
`timescale 1ns/1ps
module scdb_buffers
    import scdb_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       reset,
    input  wire logic                       hsel,
    input  wire logic [31:0]                haddr,
    input  wire logic [1:0]                 htrans,
    input  wire logic                       hwrite,
    input  wire logic [scdb_pkg::HSIZE_W-1:0] hsize,
    input  wire logic [31:0]                hwdata,
    input  wire logic                       hready,
    output logic                            hreadyout,
    output logic [31:0]                     hrdata,
    output logic                            hresp,
    input  wire logic                       txTriggerEnable,
    input  wire logic                       txTriggerEvent,
    input  wire logic                       txLoad,
    output scdb_pkg::scdb_word_t            txData,
    output logic [scdb_pkg::TCI_W-1:0]      txControlInfo,
    output logic                            txWordValid,
    output logic                            txTriggerSeen,
    input  wire logic                       rxLoadA,
    input  wire logic                       rxLoadB,
    input  wire scdb_pkg::scdb_word_t       rxData,
    input  wire logic [scdb_pkg::WLEN_W-1:0] rxBits,
    input  wire logic                       rxFrameStart,
    input  wire logic                       rxArg,
    input  wire logic                       rxArgExpect,
    output logic                            rxDoneFlag,
    output logic                            altRxFlag
);
    import scdb_pkg::*;

    scdb_slot_if slotA ();
    scdb_slot_if slotB ();

    logic              dpActive_q;
    logic              dpWrite_q;
    scdb_addr_t        dpAddr_q;
    logic [3:0]        dpLanes_q;
    scdb_word_t        txBuffer_q;
    logic [TCI_W-1:0]  txCtrlInfo_q;
    logic              txValid_q;
    logic              txTrigger_q;
    logic              rxDone_q;
    logic              altRx_q;
    logic              select_q;
    logic              select_d;

    logic wrEn;
    logic rdEn;
    logic isTx;
    logic wrTx;
    logic wrModify;
    logic wrProto;
    logic popView;
    logic popA;
    logic popB;
    logic clearA;
    logic clearB;
    logic nextValidA;
    logic nextValidB;
    logic [1:0] modifyCode;

    // Status word of one buffer with the shared valid and selector copies
    function automatic scdb_word_t status_word(input logic [WLEN_W-1:0] bits,
                                               input logic sof, input logic par,
                                               input logic perr, input logic va,
                                               input logic vb, input logic sel);
        scdb_word_t s;
        s = '0; // R17
        s[ST_WLEN_LSB +: WLEN_W] = bits;
        s[ST_SOF_BIT]    = sof;
        s[ST_PAR_BIT]    = par;
        s[ST_PERR_BIT]   = perr;
        s[ST_VALID_A]    = va;
        s[ST_VALID_B]    = vb;
        s[ST_SELECT_BIT] = sel;
        return s;
    endfunction : status_word

    // Bus address phase capture; the slave never inserts wait states
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            dpActive_q <= 1'b0;
            dpWrite_q  <= 1'b0;
            dpAddr_q   <= '0;
            dpLanes_q  <= '0;
        end else if (hready) begin
            dpActive_q <= hsel && htrans[1];
            dpWrite_q  <= hwrite;
            dpAddr_q   <= haddr[ADDR_W-1:0];
            dpLanes_q  <= lane_mask(hsize, haddr[1:0]);
        end
    end

    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign wrEn       = dpActive_q && dpWrite_q;
    assign rdEn       = dpActive_q && !dpWrite_q;
    assign isTx       = dpAddr_q <= TX_ENTRY_LAST; // R1
    assign wrTx       = wrEn && isTx;
    assign wrModify   = wrEn && dpAddr_q == FLAG_MODIFY;
    assign wrProto    = wrEn && dpAddr_q == PROTO_STATUS;
    assign popView    = rdEn && dpAddr_q == COMBINED_RX_VIEW;
    assign popA       = popView && !select_q; // R13
    assign popB       = popView && select_q; // R14
    assign modifyCode = dpLanes_q[0] ? hwdata[FM_MODIFY_LSB +: 2] : 2'h0;
    assign clearA     = popA || (wrModify && dpLanes_q[1] && hwdata[FM_CLEAR_A]); // R18
    assign clearB     = popB || (wrModify && dpLanes_q[1] && hwdata[FM_CLEAR_B]);
    assign slotA.clear = clearA;
    assign slotB.clear = clearB;

    // Transmit buffer, shared by all entry addresses
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            txBuffer_q   <= '0;
            txCtrlInfo_q <= '0;
        end else if (wrTx) begin
            if (dpLanes_q[0]) begin
                txBuffer_q[7:0] <= hwdata[7:0]; // R1
            end
            if (dpLanes_q[1]) begin
                txBuffer_q[15:8] <= hwdata[15:8]; // R1
            end
            txCtrlInfo_q <= dpAddr_q[TCI_LSB +: TCI_W]; // R2
        end
    end

    // Valid flag: software sets win over the engine's take-over
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            txValid_q <= 1'b0;
        end else if ((wrTx && dpLanes_q[0]) || (wrModify && modifyCode == MODIFY_SET)) begin
            txValid_q <= 1'b1; // R5 R19
        end else if (txLoad || (wrModify && modifyCode == MODIFY_CLEAR)) begin
            txValid_q <= 1'b0; // R19
        end
    end

    // Trigger seen: permanently set while the trigger mechanism is off
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            txTrigger_q <= 1'b0;
        end else if (!txTriggerEnable || (txTriggerEvent && txValid_q)) begin
            txTrigger_q <= 1'b1;
        end else if (txLoad || (wrModify && modifyCode == MODIFY_CLEAR)) begin
            txTrigger_q <= 1'b0; // R19
        end
    end

    assign txData        = txBuffer_q; // R4
    assign txControlInfo = txCtrlInfo_q;
    assign txWordValid   = txValid_q;
    assign txTriggerSeen = txTrigger_q;

    scdb_rx_slot u_slot_a (
        .clk        (clk),
        .reset      (reset),
        .load       (rxLoadA), // R6
        .loadData   (rxData),
        .loadBits   (rxBits),
        .loadSof    (rxFrameStart),
        .loadPar    (rxArg),
        .loadExpect (rxArgExpect),
        .sl         (slotA)
    );

    scdb_rx_slot u_slot_b (
        .clk        (clk),
        .reset      (reset),
        .load       (rxLoadB), // R7
        .loadData   (rxData),
        .loadBits   (rxBits),
        .loadSof    (rxFrameStart),
        .loadPar    (rxArg),
        .loadExpect (rxArgExpect),
        .sl         (slotB)
    );

    // Oldest-buffer selector follows the valid bits as they will be next cycle
    assign nextValidA = (slotA.valid && !clearA) || rxLoadA;
    assign nextValidB = (slotB.valid && !clearB) || rxLoadB;

    always_comb begin
        select_d = select_q;
        if (select_q ? (nextValidA && (!nextValidB || clearB))
                     : (nextValidB && (!nextValidA || clearA))) begin
            select_d = !select_q; // R16 R20
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            select_q <= 1'b0;
        end else begin
            select_q <= select_d; // R16
        end
    end

    // Receive event flags; a new word wins over a software clear
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rxDone_q <= 1'b0;
        end else if ((rxLoadA || rxLoadB) && rxArg == rxArgExpect) begin
            rxDone_q <= 1'b1; // R11
        end else if (wrProto && dpLanes_q[0] && hwdata[PS_DONE_BIT]) begin
            rxDone_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            altRx_q <= 1'b0;
        end else if ((rxLoadA || rxLoadB) && rxArg != rxArgExpect) begin
            altRx_q <= 1'b1; // R12
        end else if (wrProto && dpLanes_q[0] && hwdata[PS_ALT_BIT]) begin
            altRx_q <= 1'b0;
        end
    end

    assign rxDoneFlag = rxDone_q;
    assign altRxFlag  = altRx_q;

    // Read data during the data phase, from register state only
    always_comb begin
        hrdata = WORD_ZERO;
        if (rdEn) begin
            if (isTx) begin
                hrdata[DATA_W-1:0] = txBuffer_q; // R3
            end else begin
                unique case (dpAddr_q)
                    RX_BUFFER_A: hrdata[DATA_W-1:0] = slotA.word; // R6
                    RX_BUFFER_B: hrdata[DATA_W-1:0] = slotB.word; // R7
                    RX_STATUS_LOW: hrdata[DATA_W-1:0] = status_word(slotA.bits, slotA.sof,
                        slotA.par, slotA.perr, slotA.valid, slotB.valid, select_q);
                    RX_STATUS_HIGH: hrdata[DATA_W-1:0] = status_word(slotB.bits, slotB.sof,
                        slotB.par, slotB.perr, slotA.valid, slotB.valid, select_q); // R15
                    COMBINED_RX_VIEW: hrdata[DATA_W-1:0] = select_q ? slotB.word : slotA.word;
                    TX_CTRL_STATUS: begin
                        hrdata[TCS_VALID_BIT]             = txValid_q;
                        hrdata[TCS_TRIGGER_BIT]           = txTrigger_q;
                        hrdata[TCS_TCI_LSB +: TCI_W]      = txCtrlInfo_q;
                    end
                    PROTO_STATUS: begin
                        hrdata[PS_DONE_BIT] = rxDone_q;
                        hrdata[PS_ALT_BIT]  = altRx_q;
                    end
                    default: hrdata = WORD_ZERO;
                endcase
            end
        end
    end

    a_tx_shared_load: assert property (@(posedge clk) disable iff (reset) // R1
        wrTx && dpLanes_q[1:0] == 2'h3 |=> txData == $past(hwdata[DATA_W-1:0]))
        else $error("transmit buffer not loaded from entry write");
    a_tci_from_index: assert property (@(posedge clk) disable iff (reset) // R2
        wrTx |=> txControlInfo == $past(dpAddr_q[TCI_LSB +: TCI_W]))
        else $error("control info does not match entry index");
    a_tx_read_back: assert property (@(posedge clk) disable iff (reset) // R3
        rdEn && isTx |-> hrdata[DATA_W-1:0] == txData && hrdata[31:DATA_W] == '0)
        else $error("transmit entry read does not show buffer");
    a_low_byte_valid: assert property (@(posedge clk) disable iff (reset) // R5
        wrTx && dpLanes_q[0] |=> txWordValid)
        else $error("low byte write did not set valid");
    a_direct_read_keeps: assert property (@(posedge clk) disable iff (reset) // R6
        rdEn && dpAddr_q == RX_BUFFER_A && !rxLoadA && !clearA
        |=> slotA.valid == $past(slotA.valid))
        else $error("direct read changed valid");
    a_done_flag_set: assert property (@(posedge clk) disable iff (reset) // R11
        (rxLoadA || rxLoadB) && rxArg == rxArgExpect |=> rxDoneFlag)
        else $error("receive flag not set on matching argument");
    a_alt_flag_set: assert property (@(posedge clk) disable iff (reset) // R12
        (rxLoadA || rxLoadB) && rxArg != rxArgExpect |=> altRxFlag)
        else $error("alternative flag not set on mismatch");
    a_view_pop_clears: assert property (@(posedge clk) disable iff (reset) // R13
        popA && !rxLoadA |=> !slotA.valid)
        else $error("combined view read left buffer A valid");
    a_oldest_selected: assert property (@(posedge clk) disable iff (reset) // R16
        slotA.valid != slotB.valid |-> select_q == slotB.valid)
        else $error("selector does not point at the only valid buffer");
    a_modify_clear_a: assert property (@(posedge clk) disable iff (reset) // R18
        wrModify && dpLanes_q[1] && hwdata[FM_CLEAR_A] && !rxLoadA |=> !slotA.valid)
        else $error("clear valid write did not clear buffer A");
    a_modify_tx_clear: assert property (@(posedge clk) disable iff (reset) // R19
        wrModify && modifyCode == MODIFY_CLEAR && txTriggerEnable && !txTriggerEvent
        |=> !txWordValid && !txTriggerSeen)
        else $error("modify code did not clear valid and trigger");
    a_select_moves_on: assert property (@(posedge clk) disable iff (reset) // R20
        popA && slotB.valid && !clearB |=> select_q ##1 select_q || !slotB.valid)
        else $error("selector did not move to other buffer");
    a_pop_clears_b: assert property (@(posedge clk) disable iff (reset) // R14
        popB && !rxLoadB |=> !slotB.valid)
        else $error("buffer B still valid after pop");
    a_status_reserved: assert property (@(posedge clk) disable iff (reset) // R17
        rdEn && (dpAddr_q == RX_STATUS_LOW || dpAddr_q == RX_STATUS_HIGH)
        |-> (hrdata & 32'hffff_1cb0) == WORD_ZERO)
        else $error("reserved status bits not zero");
    a_modify_tx_set: assert property (@(posedge clk) disable iff (reset) // R19
        wrModify && modifyCode == MODIFY_SET |=> txWordValid)
        else $error("modify code did not set valid");
    a_take_clears: assert property (@(posedge clk) disable iff (reset) // R4
        txLoad && !wrTx && !wrModify |=> !txWordValid)
        else $error("taken word still valid");

    c_both_buffers_full: cover property (@(posedge clk) disable iff (reset)
        slotA.valid && slotB.valid);
    c_pop_then_flip: cover property (@(posedge clk) disable iff (reset)
        popA && slotB.valid ##1 select_q);
    c_write_then_take: cover property (@(posedge clk) disable iff (reset)
        wrTx ##[1:20] txLoad);
    c_alt_and_done: cover property (@(posedge clk) disable iff (reset)
        rxDoneFlag && altRxFlag);
    c_pop_b_back_to_a: cover property (@(posedge clk) disable iff (reset)
        popB && slotA.valid ##1 !select_q);

endmodule : scdb_buffers

/* scdb_engine_model.sv */
// Protocol engine model: receive shift registers A and B, and the transmit shift register.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/1ps
module scdb_engine_model
    import scdb_pkg::*;
(
    input  wire logic                 clk,
    input  wire scdb_pkg::scdb_word_t txData,
    output logic                      txLoad,
    output logic                      rxLoadA,
    output logic                      rxLoadB,
    output scdb_pkg::scdb_word_t      rxData,
    output logic [scdb_pkg::WLEN_W-1:0] rxBits,
    output logic                      rxFrameStart,
    output logic                      rxArg,
    output logic                      rxArgExpect
);
    import scdb_pkg::*;

    initial begin
        {txLoad, rxLoadA, rxLoadB, rxData, rxBits, rxFrameStart, rxArg, rxArgExpect} = '0;
    end

    // One-cycle store pulse; fields are inverted once the pulse is over
    task automatic receive(input logic toB, input scdb_word_t d, input logic [3:0] n,
                           input logic sof, input logic arg, input logic exp);
        @(posedge clk);
        rxLoadA      <= !toB;
        rxLoadB      <= toB;
        rxData       <= d;
        rxBits       <= n;
        rxFrameStart <= sof;
        rxArg        <= arg;
        rxArgExpect  <= exp;
        @(posedge clk);
        rxLoadA      <= 1'b0;
        rxLoadB      <= 1'b0;
        rxData       <= ~d;
        rxBits       <= ~n;
        rxFrameStart <= !sof;
        rxArg        <= !arg;
        rxArgExpect  <= !exp;
    endtask : receive

    // Takes the buffered word into the shift register
    task automatic take_tx(output scdb_word_t w);
        @(posedge clk);
        txLoad <= 1'b1;
        @(posedge clk);
        w = txData;
        txLoad <= 1'b0;
    endtask : take_tx

endmodule : scdb_engine_model

/* scdb_buffers_bench.sv */
// Self-checking testbench of the serial channel data buffers.
// Assumes the engine model on the shift side and an AHB-Lite master here.
`timescale 1ns/1ps
module scdb_buffers_bench;
    import scdb_pkg::*;
    logic        clk, reset, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        txLoad, txWordValid, txTriggerSeen, txTriggerEnable, txTriggerEvent;
    logic        rxLoadA, rxLoadB, rxFrameStart, rxArg, rxArgExpect, rxDoneFlag, altRxFlag;
    logic [4:0]  txControlInfo;
    logic [3:0]  rxBits;
    scdb_word_t  txData, rxData, w, taken;
    int          numErrors, checksDone;

    scdb_buffers scdb_buffers_i (.clk(clk), .reset(reset), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .txTriggerEnable(txTriggerEnable),
        .txTriggerEvent(txTriggerEvent), .txLoad(txLoad), .txData(txData),
        .txControlInfo(txControlInfo), .txWordValid(txWordValid), .txTriggerSeen(txTriggerSeen),
        .rxLoadA(rxLoadA), .rxLoadB(rxLoadB), .rxData(rxData), .rxBits(rxBits),
        .rxFrameStart(rxFrameStart), .rxArg(rxArg), .rxArgExpect(rxArgExpect),
        .rxDoneFlag(rxDoneFlag), .altRxFlag(altRxFlag));

    scdb_engine_model scdb_engine_model_i (.clk(clk), .txData(txData), .txLoad(txLoad),
        .rxLoadA(rxLoadA), .rxLoadB(rxLoadB), .rxData(rxData), .rxBits(rxBits),
        .rxFrameStart(rxFrameStart), .rxArg(rxArg), .rxArgExpect(rxArgExpect));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", checksDone, numErrors);
        if (numErrors == 0 && checksDone > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            numErrors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        if (n >= 100) begin
            numErrors++;
            report_and_stop;
        end
    endtask : wait_ready

    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [2:0] sz);
        @(posedge clk);
        haddr  <= {20'h0, a};
        hsize  <= sz;
        hwrite <= wr;
        htrans <= 2'h2;
        wait_ready;
        htrans <= 2'h0;
        hwdata <= wr ? d : WORD_ZERO;
        wait_ready;
        rd = hrdata;
        #1;
    endtask : bus

    task automatic bw(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 3'h2);
    endtask : bw

    task automatic br(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, WORD_ZERO, 3'h2);
        chk(rd, exp);
    endtask : br

    initial begin
        {haddr, hwdata, htrans, hwrite, txTriggerEvent, txTriggerEnable} = '0;
        hsize = 3'h2;
        numErrors = 0;
        checksDone = 0;
        reset = 1'b1;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        br(RX_STATUS_LOW, 32'h0);
        txTriggerEnable <= 1'b1;
        bw(FLAG_MODIFY, 32'h2);
        for (int i = 0; i < 32; i++) begin
            w = 16'h5a00 + 16'(i) * 16'h0103;
            bw(12'(i * 4), {16'hffff, w});
            chk(txData, w);
            chk(txControlInfo, i);
            chk(txWordValid, 1);
            br(12'(((i + 7) % 32) * 4), w);
            bw(FLAG_MODIFY, MODIFY_CLEAR);
            chk(txWordValid, 0);
        end
        bw(FLAG_MODIFY, MODIFY_SET);
        chk(txWordValid, 1);
        @(posedge clk) txTriggerEvent <= 1'b1;
        @(posedge clk) txTriggerEvent <= 1'b0;
        #1 chk(txTriggerSeen, 1);
        scdb_engine_model_i.take_tx(taken);
        #1 chk(taken, w);
        chk({txWordValid, txTriggerSeen}, 0);
        bw(FLAG_MODIFY, MODIFY_SET);
        @(posedge clk) txTriggerEvent <= 1'b1;
        @(posedge clk) txTriggerEvent <= 1'b0;
        #1 bw(FLAG_MODIFY, MODIFY_CLEAR);
        chk({txWordValid, txTriggerSeen}, 0);
        bus(1'b1, 12'h001, 32'h0000_c300, HSIZE_BYTE);
        chk({txWordValid, txData}, {1'b0, 8'hc3, w[7:0]});
        bus(1'b1, 12'h000, 32'h0000_0042, HSIZE_BYTE);
        chk({txWordValid, txData}, {1'b1, 16'hc342});
        scdb_engine_model_i.receive(1'b0, 16'habcd, 4'h7, 1'b1, 1'b1, 1'b1);
        #1 br(RX_STATUS_LOW, 32'h2147);
        chk({rxDoneFlag, altRxFlag}, 2'b10);
        br(RX_BUFFER_A, 32'h00cd);
        br(RX_STATUS_LOW, 32'h2147);
        scdb_engine_model_i.receive(1'b1, 16'h1234, 4'hf, 1'b0, 1'b0, 1'b1);
        #1 chk(altRxFlag, 1);
        br(RX_BUFFER_B, 32'h1234);
        br(RX_STATUS_LOW, 32'h6147);
        br(RX_STATUS_HIGH, 32'h620f);
        br(COMBINED_RX_VIEW, 32'h00cd);
        br(RX_STATUS_LOW, 32'hc147);
        br(RX_STATUS_HIGH, 32'hc20f);
        br(COMBINED_RX_VIEW, 32'h1234);
        br(RX_STATUS_HIGH, 32'h820f);
        scdb_engine_model_i.receive(1'b0, 16'h00ff, 4'h3, 1'b0, 1'b0, 1'b0);
        #1 br(RX_STATUS_LOW, 32'h2003);
        br(RX_BUFFER_A, 32'h000f);
        bw(FLAG_MODIFY, 32'h4000);
        br(RX_STATUS_LOW, 32'h0003);
        bus(1'b0, RX_STATUS_HIGH, WORD_ZERO, 3'h2);
        chk(rd & 32'he000, 32'h0);
        br(FLAG_MODIFY, 32'h0);
        br(12'h200, 32'h0);
        chk(hresp, 0);
        report_and_stop;
    end
endmodule : scdb_buffers_bench
